// ---- inc/tx_ctl_pkg.sv ----
package tx_ctl_pkg;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int NUM_LANES = 4;
  localparam int MARKER_W = 64;
  localparam int PREAMBLE_W = 56;
  localparam int SPACING_W = 16;
  localparam logic [SPACING_W-1:0] SPACING_DEFAULT = 16'h3FFF;
  localparam logic [SPACING_W-1:0] SPACING_RSFEC_50G = 16'h4FFF;
  localparam logic [PREAMBLE_W-1:0] STD_PREAMBLE = 56'hD5555555555555;
  localparam logic [7:0] START_CHAR = 8'hFB;
  localparam int ENC_INIT_CYCLES = 4;
  localparam logic [2:0] ENC_INIT_COUNT = 3'(ENC_INIT_CYCLES);
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------
  // code words on the transmit side
  // ----------------------------------------
  localparam logic [63:0] WORD_IDLE = 64'h0707070707070707;
  localparam logic [63:0] WORD_LOCAL_FAULT = 64'h0100009C0100009C;
  localparam logic [63:0] WORD_REMOTE_FAULT = 64'h0200009C0200009C;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY_R = 32'hEDB88320;

  typedef enum logic [1:0] {SEL_DATA, SEL_IDLE, SEL_LF, SEL_RF} word_sel_t;

  // ----------------------------------------
  // static and per-cycle control groups, status group
  // ----------------------------------------
  typedef struct packed {
    logic send_lfi;
    logic send_rfi;
    logic send_idle;
  } fault_ctl_t;

  typedef struct packed {
    logic fcs_ins_enable;
    logic ignore_fcs;
    logic custom_preamble_enable;
  } frame_cfg_t;

  typedef struct packed {
    logic bad_fcs;
    logic stomped_fcs;
    logic good_pkt;
    logic bad_pkt;
  } tx_stat_t;

endpackage

// ---- verilog/tx_sync3.sv ----
`timescale 1ns/10ps
module tx_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // level in and filtered level out
  input wire logic d,
  output logic q
);
  import tx_ctl_pkg::*;

  logic [SYNC_STAGES-1:0] stage_reg;
  logic q_reg;

  // change accepted only once second and third stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= '0;
      q_reg <= 1'b0;
    end else if (ce) begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], d};
      if (stage_reg[1] == stage_reg[2]) begin
        q_reg <= stage_reg[2];
      end
    end
  end

  assign q = q_reg;
endmodule

// ---- verilog/tx_path_ctl.sv ----
`timescale 1ns/10ps
// Function
// - rate select low 50G, high 40G
// - enable high sends data, low idles
// - enable drop finishes current packet first
// - send remote fault gives only RF words
// - local fault wins over remote fault
// - send idle gives only idle words, either fault wins over it
// - crc insertion appends computed FCS
// - ignore crc decides good count, insertion off
// - bad checksum packet passes unchanged, flagged
// - marker spacing default, changes under reset
// - per-lane marker values, change under reset
// - local fault status while encoder initialising
// - custom preamble replaces standard preamble
// - fifo errors only in wide variant
module tx_path_ctl #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // static configuration
  input wire logic rate_mode,
  input wire logic [tx_ctl_pkg::SPACING_W-1:0] lane_marker_spacing,
  input wire logic [tx_ctl_pkg::NUM_LANES-1:0][tx_ctl_pkg::MARKER_W-1:0] lane_marker_values,
  input wire tx_ctl_pkg::frame_cfg_t frame_cfg,
  // per-cycle control
  input wire logic tx_enable,
  input wire tx_ctl_pkg::fault_ctl_t fault_ctl,
  input wire logic [tx_ctl_pkg::PREAMBLE_W-1:0] preamble_in,
  // client byte stream
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // internal fifo events, from another domain
  input wire logic fifo_underflow_evt,
  input wire logic fifo_overflow_evt,
  // encoder side
  output logic [63:0] tx_word,
  output logic tx_word_is_data,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  output logic tx_rate_40g,
  output logic [tx_ctl_pkg::SPACING_W-1:0] marker_spacing_out,
  output logic [tx_ctl_pkg::NUM_LANES-1:0][tx_ctl_pkg::MARKER_W-1:0] marker_out,
  // status
  output logic stat_local_fault,
  output tx_ctl_pkg::tx_stat_t tx_stat,
  output logic stat_underflow_err,
  output logic stat_overflow_err
);
  import tx_ctl_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_R) : (r >> 1);
    end
    return r;
  endfunction

  // byte n of a word, lowest byte first on the wire
  function automatic logic [7:0] byte_at(input logic [63:0] w, input logic [2:0] n);
    return w[8*n +: 8];
  endfunction

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_PRE, ST_DATA, ST_FCS
  } tx_state_t;

  // ----------------------------------------
  // static configuration captured at reset release
  // ----------------------------------------
  logic cfg_taken_reg;
  logic rate_40g_reg;
  logic fcs_ins_reg;
  logic ignore_fcs_reg;
  logic [SPACING_W-1:0] spacing_reg;
  logic [NUM_LANES-1:0][MARKER_W-1:0] marker_reg;

  // static inputs held only after release; reset flops take constants
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_taken_reg <= 1'b0;
      rate_40g_reg <= 1'b0;
      fcs_ins_reg <= 1'b0;
      ignore_fcs_reg <= 1'b0;
      spacing_reg <= SPACING_DEFAULT;
      marker_reg <= '0;
    end else if (ce && !cfg_taken_reg) begin
      cfg_taken_reg <= 1'b1;
      rate_40g_reg <= rate_mode;
      fcs_ins_reg <= frame_cfg.fcs_ins_enable;
      ignore_fcs_reg <= frame_cfg.ignore_fcs;
      spacing_reg <= lane_marker_spacing;
      marker_reg <= lane_marker_values;
    end
  end

  assign tx_rate_40g = rate_40g_reg;
  assign marker_spacing_out = spacing_reg;
  assign marker_out = marker_reg;

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  tx_state_t state_reg, state_next;
  logic [2:0] init_cnt_reg;
  logic [2:0] idx_reg;
  logic [PREAMBLE_W-1:0] pre_reg;
  logic [31:0] crc_reg;
  logic [31:0] tail_reg;
  logic [7:0] byte_reg;
  logic byte_valid_reg;
  tx_stat_t stat_reg;

  wire logic force_fault = fault_ctl.send_lfi | fault_ctl.send_rfi;
  wire logic start_ok = tx_enable & ~force_fault & ~fault_ctl.send_idle;
  wire logic take_sop = (state_reg == ST_IDLE) && in_valid && in_sop && start_ok;
  wire logic take_data = (state_reg == ST_DATA) && in_valid;
  wire logic in_pre = (state_reg == ST_PRE);
  wire logic in_fcs = (state_reg == ST_FCS);
  wire logic pre_done = in_pre && (idx_reg == 3'h7);
  wire logic last_fcs = in_fcs && (idx_reg == 3'h3);
  wire logic [31:0] crc_after = crc_byte(crc_reg, in_data);
  // the sop byte is held in the tail and sent right after the preamble
  wire logic [63:0] pre_seq = {tail_reg[31:24], pre_reg};
  wire logic [7:0] pre_byte = byte_at(pre_seq, idx_reg);
  wire logic [7:0] fcs_byte = ~byte_at({32'h00000000, crc_reg}, idx_reg);
  wire logic [PREAMBLE_W-1:0] pre_sel =
    frame_cfg.custom_preamble_enable ? preamble_in : STD_PREAMBLE;

  assign in_ready = take_sop | (state_reg == ST_DATA);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: if (init_cnt_reg == ENC_INIT_COUNT) state_next = ST_IDLE;
      ST_IDLE: if (take_sop) state_next = ST_PRE;
      ST_PRE: if (pre_done) state_next = ST_DATA;
      // dropping enable mid-frame does not cut the packet
      ST_DATA: if (take_data && in_eop) state_next = fcs_ins_reg ? ST_FCS : ST_IDLE;
      ST_FCS: if (last_fcs) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_INIT;
      init_cnt_reg <= '0;
      idx_reg <= '0;
      pre_reg <= '0;
      crc_reg <= CRC_INIT;
      tail_reg <= '0;
      byte_reg <= '0;
      byte_valid_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      byte_valid_reg <= 1'b0;
      if (state_reg == ST_INIT) init_cnt_reg <= init_cnt_reg + 3'h1;
      // crc seeded from the sop byte so it covers the whole frame
      if (take_sop) begin
        pre_reg <= pre_sel;
        idx_reg <= '0;
        crc_reg <= crc_byte(CRC_INIT, in_data);
        tail_reg <= {in_data, tail_reg[31:8]};
        byte_reg <= START_CHAR;
        byte_valid_reg <= 1'b1;
      end
      if (in_pre) begin
        byte_reg <= pre_byte;
        byte_valid_reg <= 1'b1;
        idx_reg <= idx_reg + 3'h1;
      end
      // data passes unchanged, including a supplied bad checksum
      if (take_data) begin
        crc_reg <= crc_after;
        tail_reg <= {in_data, tail_reg[31:8]};
        byte_reg <= in_data;
        byte_valid_reg <= 1'b1;
        idx_reg <= '0;
      end
      if (in_fcs) begin
        byte_reg <= fcs_byte;
        byte_valid_reg <= 1'b1;
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // supplied checksum check when insertion is off
  // ----------------------------------------
  // register left by a frame followed by its own good fcs
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  wire logic eop_taken = take_data && in_eop;
  wire logic fcs_bad = ~fcs_ins_reg && (crc_after != CRC_RESIDUE);
  // a bad frame still counts as good when told to ignore the checksum
  wire logic pkt_bad = eop_taken && fcs_bad;
  wire logic pkt_good = eop_taken && (!fcs_bad || ignore_fcs_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_reg <= '0;
    end else if (ce) begin
      stat_reg.bad_fcs <= pkt_bad;
      stat_reg.stomped_fcs <= pkt_bad;
      stat_reg.good_pkt <= pkt_good;
      stat_reg.bad_pkt <= pkt_bad && !ignore_fcs_reg;
    end
  end
  assign tx_stat = stat_reg;

  // ----------------------------------------
  // word selection toward the encoder
  // ----------------------------------------
  word_sel_t sel_reg;
  // the sop cycle counts too, or the start character would be masked
  wire logic in_frame = take_sop || ((state_reg != ST_IDLE) && (state_reg != ST_INIT));
  wire word_sel_t sel_next =
    fault_ctl.send_lfi ? SEL_LF :
    fault_ctl.send_rfi ? SEL_RF :
    (fault_ctl.send_idle || !in_frame) ? SEL_IDLE : SEL_DATA;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= SEL_IDLE;
    end else if (ce) begin
      sel_reg <= sel_next;
    end
  end

  // fault and idle words replace the stream as a whole, even mid-frame
  always_comb begin
    case (sel_reg)
      SEL_LF: tx_word = WORD_LOCAL_FAULT;
      SEL_RF: tx_word = WORD_REMOTE_FAULT;
      SEL_DATA: tx_word = {56'h00000000000000, byte_reg};
      default: tx_word = WORD_IDLE;
    endcase
  end
  assign tx_word_is_data = (sel_reg == SEL_DATA);
  assign tx_byte = byte_reg;
  assign tx_byte_valid = byte_valid_reg && (sel_reg == SEL_DATA);

  // local fault reported as a level while the encoder initialises
  assign stat_local_fault = (state_reg == ST_INIT);

  // ----------------------------------------
  // fifo error status
  // ----------------------------------------
  logic under_sync, over_sync;
  logic under_prev_reg, over_prev_reg;
  logic under_err_reg, over_err_reg;

  tx_sync3 u_sync_under (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d(fifo_underflow_evt),
    .q(under_sync)
  );
  tx_sync3 u_sync_over (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d(fifo_overflow_evt),
    .q(over_sync)
  );

  // narrow variant has no fifo, so both flags stay low there
  // source toggles once per event; each toggle gives a one-cycle flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      under_prev_reg <= 1'b0;
      over_prev_reg <= 1'b0;
      under_err_reg <= 1'b0;
      over_err_reg <= 1'b0;
    end else if (ce) begin
      under_prev_reg <= under_sync;
      over_prev_reg <= over_sync;
      under_err_reg <= WIDE_VARIANT && (under_sync != under_prev_reg);
      over_err_reg <= WIDE_VARIANT && (over_sync != over_prev_reg);
    end
  end
  assign stat_underflow_err = under_err_reg;
  assign stat_overflow_err = over_err_reg;

endmodule

// ---- verification/tx_path_ctl_assertions.sv ----
`timescale 1ns/10ps
module tx_path_ctl_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // controls
  input wire logic rate_mode,
  input wire logic [tx_ctl_pkg::SPACING_W-1:0] lane_marker_spacing,
  input wire tx_ctl_pkg::frame_cfg_t frame_cfg,
  input wire tx_ctl_pkg::fault_ctl_t fault_ctl,
  input wire logic fifo_underflow_evt,
  // watched outputs
  input wire logic [63:0] tx_word,
  input wire logic tx_word_is_data,
  input wire logic tx_rate_40g,
  input wire logic [tx_ctl_pkg::SPACING_W-1:0] marker_spacing_out,
  input wire logic stat_local_fault,
  input wire tx_ctl_pkg::tx_stat_t tx_stat,
  input wire logic stat_underflow_err
);
  import tx_ctl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // edges since reset release; encoder init is long over at 7
  logic [2:0] up_reg;
  wire settled = (up_reg == 3'h7);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_reg <= 3'h0;
    end else if (ce && !settled) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  lf_word_a: assert property (
    settled && ce && fault_ctl.send_lfi |=> tx_word == WORD_LOCAL_FAULT)
    else $error("lf word");
  rf_word_a: assert property (
    settled && ce && fault_ctl[2:1] == 2'b01 |=> tx_word == WORD_REMOTE_FAULT)
    else $error("rf word");
  idle_word_a: assert property (
    settled && ce && fault_ctl == 3'b001 |=> tx_word == WORD_IDLE)
    else $error("idle word");
  no_data_a: assert property (
    settled && ce && fault_ctl != 3'b000 |=> !tx_word_is_data)
    else $error("no data");
  init_fault_a: assert property (
    up_reg < 3'h4 |-> stat_local_fault)
    else $error("init fault");
  fault_clear_a: assert property (
    settled |-> !stat_local_fault)
    else $error("fault clear");
  cfg_out_a: assert property (
    settled |-> tx_rate_40g == rate_mode && marker_spacing_out == lane_marker_spacing)
    else $error("cfg out");
  bad_fcs_a: assert property (
    tx_stat.bad_fcs |-> tx_stat.stomped_fcs && tx_stat.good_pkt == frame_cfg.ignore_fcs &&
      tx_stat.bad_pkt != frame_cfg.ignore_fcs)
    else $error("bad fcs");
  underflow_a: assert property (
    $changed(fifo_underflow_evt) |-> ##[3:6] stat_underflow_err ##1 !stat_underflow_err)
    else $error("underflow");
endmodule
bind tx_path_ctl tx_path_ctl_assertions i_tx_path_ctl_assertions (
  .clk(clk),
  .rst_b(rst_b),
  .ce(ce),
  .rate_mode(rate_mode),
  .lane_marker_spacing(lane_marker_spacing),
  .frame_cfg(frame_cfg),
  .fault_ctl(fault_ctl),
  .fifo_underflow_evt(fifo_underflow_evt),
  .tx_word(tx_word),
  .tx_word_is_data(tx_word_is_data),
  .tx_rate_40g(tx_rate_40g),
  .marker_spacing_out(marker_spacing_out),
  .stat_local_fault(stat_local_fault),
  .tx_stat(tx_stat),
  .stat_underflow_err(stat_underflow_err)
);

// ---- verification/link_partner_rx.sv ----
`timescale 1ns/10ps
module link_partner_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // byte stream from the transmitter
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid
);
  logic [7:0] rx_q[$];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q.delete();
    end else if (tx_byte_valid === 1'b1) begin
      rx_q.push_back(tx_byte);
    end
  end
endmodule

// ---- verification/tx_path_ctl_tb.sv ----
`timescale 1ns/10ps
module tx_path_ctl_tb;
  import tx_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic rate_mode = 1'b0;
  logic [SPACING_W-1:0] lane_marker_spacing = SPACING_RSFEC_50G;
  logic [NUM_LANES-1:0][MARKER_W-1:0] lane_marker_values = {64'hA1, 64'hB2, 64'hC3, 64'hD4};
  frame_cfg_t frame_cfg = 3'b100;
  fault_ctl_t fault_ctl = 3'b010;
  logic tx_enable = 1'b0;
  logic [PREAMBLE_W-1:0] preamble_in = 56'hD5A1B2C3D4E5F6;
  logic in_valid = 1'b0, in_sop = 1'b0, in_eop = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic fifo_underflow_evt = 1'b0, fifo_overflow_evt = 1'b0;
  logic in_ready, tx_word_is_data, tx_byte_valid, tx_rate_40g, stat_local_fault;
  logic stat_underflow_err, stat_overflow_err;
  logic [63:0] tx_word;
  logic [7:0] tx_byte;
  logic [SPACING_W-1:0] marker_spacing_out;
  logic [NUM_LANES-1:0][MARKER_W-1:0] marker_out;
  tx_stat_t tx_stat;
  int error_cnt = 0, check_count = 0, cyc = 0, good_n = 0, bad_n = 0, err_n = 0;
  logic [7:0] exp_q[$];

  tx_path_ctl #(.WIDE_VARIANT(1'b1)) i_tx_path_ctl (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .rate_mode(rate_mode),
    .lane_marker_spacing(lane_marker_spacing),
    .lane_marker_values(lane_marker_values),
    .frame_cfg(frame_cfg),
    .tx_enable(tx_enable),
    .fault_ctl(fault_ctl),
    .preamble_in(preamble_in),
    .in_valid(in_valid),
    .in_sop(in_sop),
    .in_eop(in_eop),
    .in_data(in_data),
    .in_ready(in_ready),
    .fifo_underflow_evt(fifo_underflow_evt),
    .fifo_overflow_evt(fifo_overflow_evt),
    .tx_word(tx_word),
    .tx_word_is_data(tx_word_is_data),
    .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid),
    .tx_rate_40g(tx_rate_40g),
    .marker_spacing_out(marker_spacing_out),
    .marker_out(marker_out),
    .stat_local_fault(stat_local_fault),
    .tx_stat(tx_stat),
    .stat_underflow_err(stat_underflow_err),
    .stat_overflow_err(stat_overflow_err)
  );
  link_partner_rx i_link_partner_rx (
    .clk(clk),
    .rst_b(rst_b),
    .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end
  // pulses counted mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    cyc++;
    good_n += int'(tx_stat.good_pkt === 1'b1);
    bad_n += int'(tx_stat.bad_fcs === 1'b1);
    err_n += int'(stat_underflow_err === 1'b1) + int'(stat_overflow_err === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
    return c;
  endfunction

  task automatic do_reset();
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // with insertion off the last four bytes carry a supplied checksum
  task automatic send_pkt(input int n, input logic bad, input logic drop);
    logic [31:0] crc;
    logic [PREAMBLE_W-1:0] pre;
    logic [7:0] b;
    logic rdy;
    int m;
    int w;
    crc = CRC_INIT;
    m = frame_cfg.fcs_ins_enable ? n : n + 4;
    pre = frame_cfg.custom_preamble_enable ? preamble_in : STD_PREAMBLE;
    i_link_partner_rx.rx_q.delete();
    exp_q = {START_CHAR};
    for (int i = 0; i < 7; i++) exp_q.push_back(pre[8*i +: 8]);
    for (int i = 0; i < m; i++) begin
      b = (i < n) ? 8'(i * 29 + 1) : ~crc[8*(i-n) +: 8] ^ {7'h0, bad};
      if (i < n) crc = crc_step(crc, b);
      exp_q.push_back(b);
      in_valid = 1'b1;
      in_sop = (i == 0);
      in_eop = (i == m - 1);
      in_data = b;
      w = 0;
      do begin
        @(negedge clk);
        rdy = in_ready;
        @(posedge clk);
        w++;
      end while (rdy !== 1'b1 && w < 50);
      #1;
      if (drop) tx_enable = 1'b0;
    end
    in_valid = 1'b0;
    in_eop = 1'b0;
    for (int k = 0; k < 4 && frame_cfg.fcs_ins_enable; k++) exp_q.push_back(~crc[8*k +: 8]);
    repeat (30) @(posedge clk);
    #1;
    cmp(i_link_partner_rx.rx_q.size(), exp_q.size());
    foreach (exp_q[j]) cmp(i_link_partner_rx.rx_q[j], exp_q[j]);
  endtask

  initial begin
    do_reset();
    for (int f = 0; f < 8; f++) begin
      fault_ctl = 3'(f);
      repeat (2) @(posedge clk);
      #1 cmp(tx_word,
        f[2] ? WORD_LOCAL_FAULT : (f[1] ? WORD_REMOTE_FAULT : WORD_IDLE));
    end
    // clock enable low must freeze the fault word already chosen
    ce = 1'b0;
    fault_ctl = 3'b000;
    repeat (3) @(posedge clk);
    #1 cmp(tx_word, WORD_LOCAL_FAULT);
    ce = 1'b1;
    cmp(64'(marker_out == lane_marker_values), 64'h1);
    fault_ctl = 3'b000;
    tx_enable = 1'b1;
    send_pkt(12, 1'b0, 1'b0);
    frame_cfg.custom_preamble_enable = 1'b1;
    send_pkt(9, 1'b0, 1'b1);
    i_link_partner_rx.rx_q.delete();
    in_valid = 1'b1;
    in_sop = 1'b1;
    repeat (12) @(posedge clk);
    #1 in_valid = 1'b0;
    in_sop = 1'b0;
    cmp(i_link_partner_rx.rx_q.size(), 64'h0);
    cmp(good_n, 64'h2);
    repeat (2) begin
      fifo_underflow_evt = ~fifo_underflow_evt;
      fifo_overflow_evt = ~fifo_overflow_evt;
      repeat (10) @(posedge clk);
      #1;
    end
    cmp(err_n, 64'h4);
    for (int ig = 0; ig < 2; ig++) begin
      rst_b = 1'b0;
      frame_cfg = {1'b0, 1'(ig), 1'b0};
      rate_mode = 1'b1;
      lane_marker_spacing = SPACING_DEFAULT;
      fault_ctl = 3'b010;
      tx_enable = 1'b0;
      do_reset();
      fault_ctl = 3'b000;
      tx_enable = 1'b1;
      good_n = 0;
      bad_n = 0;
      send_pkt(12, 1'b0, 1'b0);
      send_pkt(12, 1'b1, 1'b0);
      cmp(good_n, 64'(1 + ig));
      cmp(bad_n, 64'h1);
    end
    stop_test();
  end
endmodule
